// ==== sim/tb.sv ====
`include "asf_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import asf_pkg::*;

  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

  localparam logic [4:0] CTL = `ASF_OFS_CONTROL;
  localparam logic [4:0] STA = `ASF_OFS_STATUS;
  localparam logic [4:0] TMO = `ASF_OFS_TIMEOUT;
  localparam logic [4:0] FIF = `ASF_OFS_FIFO;
  localparam logic [2:0] CHS [3] = '{3'd1, 3'd3, 3'd6};

  logic             CLOCK;
  logic             RSTN;
  asf_host_req_type HOST_REQ;
  logic [15:0]      HOST_RDATA;
  logic             SAMPLE_REQ;
  asf_chan_type     SAMPLE_CHAN;
  logic             SAMPLE_VALID;
  asf_result_type   SAMPLE_RESULT;
  logic             SAMPLE_READY;
  logic             CAL_REQ;
  logic             ZERO_REQ;
  int               n_mismatch = 0;
  int               n_checks = 0;
  int               cyc = 0;
  int               n_req = 0;
  logic [15:0]      rv;

  asf_sequencer i_dut (
    .CLOCK         (CLOCK),
    .RSTN          (RSTN),
    .HOST_REQ      (HOST_REQ),
    .HOST_RDATA    (HOST_RDATA),
    .SAMPLE_REQ    (SAMPLE_REQ),
    .SAMPLE_CHAN   (SAMPLE_CHAN),
    .SAMPLE_VALID  (SAMPLE_VALID),
    .SAMPLE_RESULT (SAMPLE_RESULT),
    .SAMPLE_READY  (SAMPLE_READY),
    .CAL_REQ       (CAL_REQ),
    .ZERO_REQ      (ZERO_REQ)
  );

  // ---------------------------------------------------------------
  // Host access and converter side
  // ---------------------------------------------------------------
  function automatic logic [15:0] pt(logic [2:0] c, logic t, logic p, logic l);
    return {6'h00, t, 1'b0, 3'h0, c, p, l};
  endfunction

  function automatic logic [15:0] sta(logic [4:0] c, logic [2:0] p);
    return {c, p, 8'h00};
  endfunction

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    HOST_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge CLOCK);
    HOST_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge CLOCK);
  endtask

  task automatic chk_rd(input logic [4:0] a, input logic [15:0] e);
    HOST_REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge CLOCK);
    HOST_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    @(negedge CLOCK);
    rv = HOST_RDATA;
    `CHK(rv, e)
    @(posedge CLOCK);
  endtask

  // Waits for a request, offers one result and returns the wait in cycles
  task automatic conv(input logic s, input logic [11:0] v, output asf_chan_type sel, output int n);
    n = 0;
    @(negedge CLOCK);
    while (SAMPLE_REQ !== 1'b1 && n < 400)
    begin
      @(negedge CLOCK);
      n++;
    end
    sel = SAMPLE_CHAN;
    @(posedge CLOCK);
    SAMPLE_VALID <= 1'b1;
    SAMPLE_RESULT <= '{sign: s, value: v};
    do @(posedge CLOCK); while (SAMPLE_READY !== 1'b1);
    SAMPLE_VALID <= 1'b0;
    SAMPLE_RESULT <= '{sign: ~s, value: ~v};
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK)
  begin
    cyc++;
    if (SAMPLE_REQ === 1'b1)
      n_req++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, cyc, 0);
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    asf_chan_type sel;
    int           n;
    RSTN = 1'b0;
    HOST_REQ = '0;
    SAMPLE_VALID = 1'b0;
    SAMPLE_RESULT = '0;
    repeat (16) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    chk_rd(CTL, 16'h0000);
    chk_rd(STA, 16'h0000);
    chk_rd(TMO, 16'h0000);
    chk_rd(FIF, 16'h0000);
    wr(TMO, 16'hbeef);
    chk_rd(TMO, 16'hbeef);
    wr(STA, 16'hffff);
    chk_rd(STA, 16'h0000);
    wr(5'h1a, 16'h1234);
    chk_rd(5'h1a, 16'h0000);
    $display("test registers done");

    wr(CTL, 16'h0002);
    HOST_REQ <= '{wr: 1'b1, rd: 1'b0, addr: CTL, wdata: 16'h000c};
    @(posedge CLOCK);
    HOST_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~CTL, wdata: 16'hfff3};
    @(negedge CLOCK);
    `CHK({CAL_REQ, ZERO_REQ}, 2'b11)
    @(negedge CLOCK);
    `CHK({CAL_REQ, ZERO_REQ}, 2'b00)
    @(posedge CLOCK);
    chk_rd(CTL, 16'h000c);
    wr(5'h00, pt(CHS[0], 1'b0, 1'b0, 1'b0));
    wr(5'h02, pt(CHS[1], 1'b0, 1'b1, 1'b0));
    wr(5'h04, pt(CHS[2], 1'b0, 1'b0, 1'b1));
    chk_rd(5'h02, pt(CHS[1], 1'b0, 1'b1, 1'b0));
    wr(CTL, 16'h0000);
    wr(CTL, 16'h0002);
    wr(CTL, 16'h0001);
    for (int i = 0; i < 5; i++)
    begin
      if (i == 2)
      begin
        chk_rd(CTL, 16'h0000);
        wr(CTL, 16'h0001);
      end
      conv(i[0], 12'(12'h100 + i), sel, n);
      `CHK(sel.pos_sel, CHS[i % 3])
    end
    repeat (4) @(posedge CLOCK);
    chk_rd(CTL, 16'h0000);
    chk_rd(STA, sta(5'd5, 3'd2));
    for (int i = 0; i < 4; i++)
    begin
      chk_rd(FIF, {3'(i % 3), i[0], 12'(12'h100 + i)});
      chk_rd(STA, sta(5'(4 - i), 3'd2));
    end
    $display("test point format done");

    wr(CTL, 16'h0002);
    chk_rd(STA, 16'h0000);
    chk_rd(FIF, 16'h0000);
    wr(5'h00, pt(3'd5, 1'b1, 1'b1, 1'b1));
    wr(CTL, 16'h0002);
    for (int k = 0; k < 2; k++)
    begin
      wr(TMO, 16'(2 * k));
      wr(CTL, 16'h0821);
      conv(k == 0, (k == 0) ? 12'habc : 12'h123, sel, n);
      `CHK(n >= (64*k+2)*34/10-3 && n <= (64*k+2)*34/10+5, 1'b1)
      `CHK(sel, 7'h45)
      repeat (4) @(posedge CLOCK);
      chk_rd(FIF, (k == 0) ? 16'hfabc : 16'h0123);
    end
    $display("test sign format and delay done");

    wr(CTL, 16'h0002);
    wr(5'h00, pt(3'd2, 1'b0, 1'b0, 1'b1));
    wr(CTL, 16'h0002);
    wr(CTL, 16'h0001);
    for (int i = 0; i < 33; i++)
      conv(1'b0, 12'(i + 1), sel, n);
    while (SAMPLE_REQ !== 1'b1) @(negedge CLOCK);
    @(posedge CLOCK);
    SAMPLE_VALID <= 1'b1;
    SAMPLE_RESULT <= '{sign: 1'b0, value: 12'h022};
    repeat (6) @(negedge CLOCK);
    `CHK(SAMPLE_READY, 1'b0)
    @(posedge CLOCK);
    chk_rd(STA, sta(5'd31, 3'd0));
    chk_rd(FIF, 16'h0001);
    do @(posedge CLOCK); while (SAMPLE_READY !== 1'b1);
    SAMPLE_VALID <= 1'b0;
    repeat (4) @(posedge CLOCK);
    chk_rd(STA, sta(5'd31, 3'd0));
    chk_rd(FIF, 16'h0002);
    // Stop while a request is outstanding: it completes, no new one follows
    wr(CTL, 16'h0000);
    n = n_req;
    SAMPLE_VALID <= 1'b1;
    SAMPLE_RESULT <= '{sign: 1'b0, value: 12'h023};
    do @(posedge CLOCK); while (SAMPLE_READY !== 1'b1);
    SAMPLE_VALID <= 1'b0;
    for (int i = 0; i < 30; i++)
      chk_rd(FIF, 16'(i + 3));
    chk_rd(STA, sta(5'd3, 3'd0));
    for (int i = 0; i < 3; i++)
      chk_rd(FIF, 16'(i + 33));
    `CHK(n_req, n)
    wr(CTL, 16'h0002);
    chk_rd(STA, 16'h0000);
    $display("test buffer full done");
    close_out();
  end

endmodule

// ==== verilog/asf_defs.svh ====
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses from the base I/O address)
// ---------------------------------------------------------------
`define ASF_ADDR_W             5
`define ASF_OFS_CONTROL        5'h10
`define ASF_OFS_STATUS         5'h14
`define ASF_OFS_TIMEOUT        5'h16
`define ASF_OFS_FIFO           5'h18

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ASF_CTL_START          0
`define ASF_CTL_RESET          1
`define ASF_CTL_ZERO           2
`define ASF_CTL_CAL            3
`define ASF_CTL_TAG_SEL        5
`define ASF_CTL_STORE_MASK     16'h0ffc
`define ASF_STA_COUNT_LSB      11
`define ASF_STA_POINT_LSB      8
`define ASF_WORD_TAG_LSB       13

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ASF_RST_POINT          16'h0000
`define ASF_RST_CONTROL        16'h0000
`define ASF_RST_TIMEOUT        16'h0000

// ---------------------------------------------------------------
// Sizes and timing
// ---------------------------------------------------------------
`define ASF_NUM_POINTS         8
`define ASF_FIFO_DEPTH         31
`define ASF_FIFO_CW            5
`define ASF_BUF_DEPTH          2
`define ASF_BUF_CW             2
`define ASF_DELAY_MULT         32
`define ASF_DELAY_EXTRA        2
`define ASF_CONV_CLK_PERIOD_US 0.136
`define ASF_SYS_CLK_PERIOD_NS  40

`endif

// ==== verilog/asf_delay_timer.sv ====
`include "asf_defs.svh"

module asf_delay_timer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [15:0] delay,
  output logic             busy,
  output logic             done
);

  localparam int SYS_NS  = `ASF_SYS_CLK_PERIOD_NS;
  localparam int CONV_NS = int'(`ASF_CONV_CLK_PERIOD_US * 1000.0);
  localparam int AW      = 8;
  localparam int RW      = 22;

  logic [AW-1:0] acc_q;
  logic [RW-1:0] rem_q;
  logic          busy_q;
  logic          done_q;
  wire  [AW:0]   acc_sum = {1'b0, acc_q} + (AW+1)'(SYS_NS);
  wire           tick    = (acc_sum >= (AW+1)'(CONV_NS));
  wire  [AW-1:0] acc_d   = tick ? AW'(acc_sum - (AW+1)'(CONV_NS)) : acc_sum[AW-1:0];
  wire  [RW-1:0] load    = RW'(delay) * RW'(`ASF_DELAY_MULT) + RW'(`ASF_DELAY_EXTRA);

  assign busy = busy_q;
  assign done = done_q;

  // ---------------------------------------------------------------
  // Converter clock enable and stall counter
  // ---------------------------------------------------------------
  // Phase accumulator gives an exact 136 ns average tick from 40 ns
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      acc_q <= '0;
    else
      acc_q <= start ? '0 : acc_d;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rem_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        rem_q  <= load;
        busy_q <= 1'b1;
      end
      else if (abort)
        busy_q <= 1'b0;
      else if (busy_q && tick)
      begin
        rem_q <= rem_q - 1'b1;
        if (rem_q == RW'(1))
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [RW-1:0] chk_ticks_q;
  logic [RW-1:0] chk_exp_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chk_ticks_q <= '0;
      chk_exp_q   <= '0;
    end
    else if (start)
    begin
      chk_ticks_q <= '0;
      chk_exp_q   <= load;
    end
    else if (busy_q && tick)
      chk_ticks_q <= chk_ticks_q + 1'b1;
  end

  a_delay_ticks: assert property (@(posedge clk) disable iff (!rstn)
    done |-> chk_ticks_q == chk_exp_q)
    else $error("stall length differs from 32*delay+2 ticks");

  a_tick_spacing: assert property (@(posedge clk) disable iff (!rstn)
    tick |=> !tick ##1 !tick)
    else $error("converter tick faster than its period");

endmodule

// ==== verilog/asf_fifo.sv ====
module asf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2,
  parameter int CW    = 2
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CW-1:0]         count
);

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [IW-1:0]    wr_q;
  logic [IW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire [IW-1:0]     wr_next = (wr_q == LAST) ? '0 : wr_q + 1'b1;
  wire [IW-1:0]     rd_next = (rd_q == LAST) ? '0 : rd_q + 1'b1;

  assign in_ready  = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;

  assign cnt_d = flush ? '0 :
                 (push && !pop) ? cnt_q + 1'b1 :
                 (pop && !push) ? cnt_q - 1'b1 : cnt_q;

  // ---------------------------------------------------------------
  // Storage, one flop word per entry
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        mem_q[i] <= '0;
      else if (push && wr_q == IW'(i))
        mem_q[i] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= flush ? '0 : (push ? wr_next : wr_q);
      rd_q  <= flush ? '0 : (pop ? rd_next : rd_q);
      cnt_q <= cnt_d;
    end
  end

endmodule

// ==== verilog/asf_pkg.sv ====
`include "asf_defs.svh"

package asf_pkg;

  // ---------------------------------------------------------------
  // Point list entry
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] settle;
    logic [1:0] rsv_hi;
    logic       timer;
    logic       rsv_lo;
    logic [2:0] neg_sel;
    logic [2:0] pos_sel;
    logic       pause;
    logic       loop;
  } asf_point_type;

  // ---------------------------------------------------------------
  // Host access and converter carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [`ASF_ADDR_W-1:0]   addr;
    logic [15:0]              wdata;
  } asf_host_req_type;

  typedef struct packed {
    logic       diag;
    logic [2:0] neg_sel;
    logic [2:0] pos_sel;
  } asf_chan_type;

  typedef struct packed {
    logic        sign;
    logic [11:0] value;
  } asf_result_type;

  typedef enum logic {ASF_TAG_POINT, ASF_TAG_SIGN} asf_tag_fmt_type;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_REQ, SEQ_WAIT} asf_seq_state_type;

endpackage

// ==== verilog/asf_sequencer.sv ====
`include "asf_defs.svh"

module asf_sequencer (
  input  wire logic                      CLOCK,
  input  wire logic                      RSTN,
  input  wire asf_pkg::asf_host_req_type HOST_REQ,
  output logic [15:0]                    HOST_RDATA,
  output logic                           SAMPLE_REQ,
  output asf_pkg::asf_chan_type          SAMPLE_CHAN,
  input  wire logic                      SAMPLE_VALID,
  input  wire asf_pkg::asf_result_type   SAMPLE_RESULT,
  output logic                           SAMPLE_READY,
  output logic                           CAL_REQ,
  output logic                           ZERO_REQ
);
  import asf_pkg::*;

  localparam int NP = `ASF_NUM_POINTS;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  asf_point_type     point_q [NP];
  logic [15:0]       ctl_q;
  logic              start_q;
  logic [15:0]       timeout_q;
  logic              cal_q;
  logic              zero_q;
  logic [15:0]       rdata_q;

  wire               addr_is_point = (HOST_REQ.addr[4] == 1'b0) && (HOST_REQ.addr[0] == 1'b0);
  wire [2:0]         point_sel     = HOST_REQ.addr[3:1];
  wire               wr_point      = HOST_REQ.wr && addr_is_point;
  wire               ctl_wr        = HOST_REQ.wr && (HOST_REQ.addr == `ASF_OFS_CONTROL);
  wire               timeout_wr    = HOST_REQ.wr && (HOST_REQ.addr == `ASF_OFS_TIMEOUT);
  wire               rst_pulse     = ctl_wr && HOST_REQ.wdata[`ASF_CTL_RESET];
  wire               fifo_rd       = HOST_REQ.rd && (HOST_REQ.addr == `ASF_OFS_FIFO);
  asf_tag_fmt_type   tag_fmt;

  assign tag_fmt = asf_tag_fmt_type'(ctl_q[`ASF_CTL_TAG_SEL]);

  for (genvar i = 0; i < NP; i++)
  begin : g_point
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
      if (!RSTN)
        point_q[i] <= asf_point_type'(`ASF_RST_POINT);
      else if (wr_point && point_sel == 3'(i))
        point_q[i] <= asf_point_type'(HOST_REQ.wdata);
    end
  end

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  asf_seq_state_type state_q;
  asf_seq_state_type state_d;
  logic [2:0]        ptr_q;
  logic [2:0]        tag_q;
  asf_chan_type      chan_q;
  logic              timer_busy;
  logic              timer_done;
  logic              buf_in_ready;

  asf_point_type     cur;
  assign cur = point_q[ptr_q];

  wire               go          = (state_q == SEQ_IDLE) && start_q && !rst_pulse;
  wire               timer_start = go && cur.timer;
  wire               accept      = SAMPLE_VALID && SAMPLE_READY;
  wire [2:0]         ptr_next    = (cur.loop || ptr_q == 3'(NP - 1)) ? 3'h0 : ptr_q + 3'h1;
  wire               hw_stop     = accept && cur.pause;

  assign SAMPLE_REQ   = (state_q == SEQ_REQ);
  assign SAMPLE_READY = (state_q == SEQ_WAIT) && buf_in_ready;
  assign SAMPLE_CHAN  = chan_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SEQ_IDLE:
        if (go)
          state_d = cur.timer ? SEQ_DELAY : SEQ_REQ;
      SEQ_DELAY:
        if (timer_done)
          state_d = SEQ_REQ;
      SEQ_REQ:
        state_d = SEQ_WAIT;
      SEQ_WAIT:
        if (accept)
          state_d = SEQ_IDLE;
      default:
        state_d = SEQ_IDLE;
    endcase
    if (rst_pulse)
      state_d = SEQ_IDLE;
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q <= SEQ_IDLE;
      ptr_q   <= 3'h0;
      tag_q   <= 3'h0;
      chan_q  <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (rst_pulse)
        ptr_q <= 3'h0;
      else if (accept)
        ptr_q <= ptr_next;
      if (go)
      begin
        tag_q  <= ptr_q;
        chan_q <= '{diag: ctl_q[11], neg_sel: cur.neg_sel, pos_sel: cur.pos_sel};
      end
    end
  end

  // ---------------------------------------------------------------
  // Control, timeout and calibration requests
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctl_q     <= `ASF_RST_CONTROL;
      start_q   <= 1'b0;
      timeout_q <= `ASF_RST_TIMEOUT;
      cal_q     <= 1'b0;
      zero_q    <= 1'b0;
    end
    else
    begin
      cal_q  <= ctl_wr && HOST_REQ.wdata[`ASF_CTL_CAL];
      zero_q <= ctl_wr && HOST_REQ.wdata[`ASF_CTL_ZERO];
      if (ctl_wr)
        ctl_q <= HOST_REQ.wdata & `ASF_CTL_STORE_MASK;
      // A host write of start wins over the hardware stop
      if (rst_pulse)
        start_q <= 1'b0;
      else if (ctl_wr)
        start_q <= HOST_REQ.wdata[`ASF_CTL_START];
      else if (hw_stop)
        start_q <= 1'b0;
      if (timeout_wr)
        timeout_q <= HOST_REQ.wdata;
    end
  end

  assign CAL_REQ  = cal_q;
  assign ZERO_REQ = zero_q;

  asf_delay_timer u_timer (
    .clk   (CLOCK),
    .rstn  (RSTN),
    .start (timer_start),
    .abort (rst_pulse),
    .delay (timeout_q),
    .busy  (timer_busy),
    .done  (timer_done)
  );

  // ---------------------------------------------------------------
  // Result formatting and data path
  // ---------------------------------------------------------------
  wire [2:0]  word_tag = (tag_fmt == ASF_TAG_SIGN) ? {3{SAMPLE_RESULT.sign}} : tag_q;
  wire [15:0] buf_word = {word_tag, SAMPLE_RESULT.sign, SAMPLE_RESULT.value};

  logic                     buf_out_valid;
  logic [15:0]              buf_out_data;
  logic                     conv_in_ready;
  logic                     fifo_valid;
  logic [15:0]              fifo_data;
  logic [`ASF_FIFO_CW-1:0]  fifo_count;

  asf_fifo #(
    .WIDTH (16),
    .DEPTH (`ASF_BUF_DEPTH),
    .CW    (`ASF_BUF_CW)
  ) u_buf (
    .clk       (CLOCK),
    .rstn      (RSTN),
    .flush     (rst_pulse),
    .in_valid  (SAMPLE_VALID && state_q == SEQ_WAIT),
    .in_ready  (buf_in_ready),
    .in_data   (buf_word),
    .out_valid (buf_out_valid),
    .out_ready (conv_in_ready),
    .out_data  (buf_out_data),
    .count     ()
  );

  // The result FIFO has no bypass; every word passes through it
  asf_fifo #(
    .WIDTH (16),
    .DEPTH (`ASF_FIFO_DEPTH),
    .CW    (`ASF_FIFO_CW)
  ) u_conv_fifo (
    .clk       (CLOCK),
    .rstn      (RSTN),
    .flush     (rst_pulse),
    .in_valid  (buf_out_valid),
    .in_ready  (conv_in_ready),
    .in_data   (buf_out_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_rd),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  // ---------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------
  wire [15:0] status_word = {fifo_count, ptr_q, 8'h00};
  wire [15:0] ctl_word    = ctl_q | {15'h0000, start_q};
  // An empty FIFO reads as zero and is left untouched
  wire [15:0] fifo_word   = fifo_valid ? fifo_data : 16'h0000;
  wire [15:0] rd_word     = addr_is_point ? 16'(point_q[point_sel]) :
                            (HOST_REQ.addr == `ASF_OFS_CONTROL) ? ctl_word :
                            (HOST_REQ.addr == `ASF_OFS_STATUS)  ? status_word :
                            (HOST_REQ.addr == `ASF_OFS_TIMEOUT) ? timeout_q :
                            (HOST_REQ.addr == `ASF_OFS_FIFO)    ? fifo_word : 16'h0000;

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      rdata_q <= 16'h0000;
    else if (HOST_REQ.rd)
      rdata_q <= rd_word;
  end

  assign HOST_RDATA = rdata_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  wire conv_push = buf_out_valid && conv_in_ready;

  a_status_count: assert property (
    HOST_REQ.rd && HOST_REQ.addr == `ASF_OFS_STATUS |=> HOST_RDATA[15:11] == $past(fifo_count))
    else $error("status count differs from FIFO occupancy");

  a_fifo_pop: assert property (
    fifo_rd && fifo_count != '0 && !conv_push && !rst_pulse
      |=> fifo_count == $past(fifo_count) - 5'h01)
    else $error("result read did not pop one word");

  a_tag_point: assert property (
    accept && tag_fmt == ASF_TAG_POINT |-> buf_word[15:13] == ptr_q)
    else $error("result tag is not the point position");

  a_tag_sign: assert property (
    accept && tag_fmt == ASF_TAG_SIGN |-> buf_word[15:13] == {3{buf_word[12]}})
    else $error("result top bits not sign extended");

  a_value_bits: assert property (
    accept |-> buf_word[12] == SAMPLE_RESULT.sign && buf_word[11:0] == SAMPLE_RESULT.value)
    else $error("result sign or value misplaced");

  a_pause_stop: assert property (
    hw_stop && !ctl_wr |=> !start_q ##1 state_q == SEQ_IDLE)
    else $error("pause point did not stop sequencing");

  a_loop_wrap: assert property (
    accept && cur.loop && !rst_pulse |=> ptr_q == 3'h0)
    else $error("loop point did not wrap to point zero");

  a_reset_flush: assert property (
    rst_pulse |=> state_q == SEQ_IDLE && ptr_q == 3'h0 && fifo_count == '0 && !start_q)
    else $error("control reset did not halt and flush");

  a_timer_stall: assert property (
    timer_busy |-> !SAMPLE_REQ && state_q == SEQ_DELAY)
    else $error("conversion requested during delay stall");

  a_timer_resume: assert property (
    timer_done && state_q == SEQ_DELAY && !rst_pulse |=> SAMPLE_REQ ##1 !SAMPLE_REQ)
    else $error("stalled point not sampled after delay");

endmodule
